// ==== hw/csmi_pkg.sv ====
// Constants and types for the codec serial mode interpreter.
`default_nettype none

package csmi_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned SYS_CLK_HZ   = 10_000_000;
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned SCLK_DIV     = 8;
  localparam int unsigned DEF_FS_DIV   = 2048;
  localparam int unsigned FAST_FS_DIV  = 256;
  localparam logic [8:0]  DEF_FS_BITS  = 9'(DEF_FS_DIV / SCLK_DIV);
  localparam logic [8:0]  FAST_FS_BITS = 9'(FAST_FS_DIV / SCLK_DIV);
  localparam logic [2:0]  SAMPLE_PHASE = 3'h6;
  localparam logic [2:0]  LAUNCH_PHASE = 3'h7;
  localparam logic [3:0]  LAST_BIT     = 4'hf;

  // ==========================================================
  // Control word layout
  localparam int unsigned FLAG_BIT = 15;
  localparam int unsigned ADDR_MSB = 14;
  localparam int unsigned ADDR_LSB = 12;
  localparam int unsigned REG_MSB  = 11;
  localparam int unsigned REG_LSB  = 8;
  localparam int unsigned VAL_MSB  = 7;
  localparam logic [2:0]  ADDR_ONE = 3'h1;

  // ==========================================================
  // Register indices, fields and reset values
  localparam logic [3:0] REG_MODE  = 4'h0;
  localparam logic [3:0] REG_RATE  = 4'h1;
  localparam logic [3:0] REG_LOOP  = 4'h5;
  localparam int unsigned MODE_DPS_BIT = 0;
  localparam int unsigned MODE_MIX_BIT = 1;
  localparam int unsigned MODE_DLP_BIT = 2;
  localparam int unsigned MODE_SLP_BIT = 3;
  localparam int unsigned MODE_CNT_LSB = 4;
  localparam int unsigned MODE_CNT_MSB = 6;
  localparam int unsigned RATE_LSB     = 0;
  localparam int unsigned RATE_MSB     = 1;
  localparam int unsigned LOOP_ANA_BIT = 7;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] LOOP_RESET = 8'h00;

  typedef enum logic [1:0] {
    CSMI_TX_IDLE,
    CSMI_TX_SYNC,
    CSMI_TX_BITS
  } csmi_tx_state_t;

endpackage

`default_nettype wire

// ==== hw/csmi_codec_serial.sv ====
// Serial front end: frame timing, frame decode and mode handling.
`default_nettype none

module csmi_codec_serial
  import csmi_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Pins from the host side
  input  wire logic        serial_enable_pin,
  input  wire logic        serial_data_in,
  input  wire logic        input_frame_sync,
  // Pins to the host side
  output logic             serial_clock_reg,
  output logic             output_frame_sync,
  output logic             serial_data_out,
  // Converter side
  input  wire logic [15:0] adc_sample,
  output logic             sample_strobe,
  output logic [15:0]      dac_data_reg,
  output logic             dac_load,
  // Configuration state
  output logic [7:0]       mode_config_register,
  output logic [7:0]       rate_config_register,
  output logic [7:0]       loop_config_register
);

  // ==========================================================
  // Pin synchronisers
  // The filtered value only moves when stages two and three agree.
  logic [2:0] pin_raw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pin_reg;

  assign pin_raw = {serial_enable_pin, input_frame_sync, serial_data_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          pin_reg[gi]   <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            pin_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire din_s = pin_reg[0];
  wire ifs_s = pin_reg[1];
  wire ena_s = pin_reg[2];

  // ==========================================================
  // Serial clock divider
  // Inputs are sampled late in the bit so the synchroniser delay
  // has settled; this is why the serial clock is slow against clk_sys.
  logic [2:0] phase_reg;
  wire  [2:0] phase_next = phase_reg + 3'h1;
  wire        sample_en  = (phase_reg == SAMPLE_PHASE);
  wire        launch_en  = (phase_reg == LAUNCH_PHASE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg        <= 3'h0;
      serial_clock_reg <= 1'b0;
    end else begin
      phase_reg        <= phase_next;
      serial_clock_reg <= ~phase_next[2];
    end
  end

  // ==========================================================
  // Mode decode
  wire       dps       = mode_config_register[MODE_DPS_BIT];
  wire       mix_bit   = mode_config_register[MODE_MIX_BIT];
  wire       dloop     = mode_config_register[MODE_DLP_BIT];
  wire       sloop     = mode_config_register[MODE_SLP_BIT];
  wire [2:0] casc_cnt  =
    mode_config_register[MODE_CNT_MSB:MODE_CNT_LSB];
  wire       prog_mode  = ~dps;
  wire       data_mode  = dps & ~mix_bit;
  wire       mixed_mode = dps & mix_bit;
  wire       cfg_open   = prog_mode | mixed_mode;

  // ==========================================================
  // Sample interval timer
  logic       rate_written_reg;
  logic [8:0] fs_cnt_reg;
  wire  [1:0] rate_sel = rate_config_register[RATE_MSB:RATE_LSB];
  wire  [8:0] fs_rate_bits = 9'(FAST_FS_BITS << (~rate_sel));
  wire  [8:0] fs_period = rate_written_reg ? fs_rate_bits : DEF_FS_BITS;
  wire        fs_wrap   = (fs_cnt_reg >= fs_period - 9'h1);
  wire        fs_tick   = ena_s & launch_en & fs_wrap;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fs_cnt_reg <= 9'h0;
    end else if (launch_en) begin
      fs_cnt_reg <= (fs_wrap || !ena_s) ? 9'h0 : fs_cnt_reg + 9'h1;
    end
  end

  // ==========================================================
  // Receiver
  logic        rx_active_reg;
  logic [3:0]  rx_cnt_reg;
  logic [15:0] rx_shift_reg;
  logic        rx_done_reg;
  logic [3:0]  ifs_count_reg;
  logic [3:0]  rx_index_reg;
  logic        interval_start;
  wire         rx_start = sample_en & ifs_s &
                          (!rx_active_reg || rx_cnt_reg == LAST_BIT);
  wire  [15:0] rx_word_next = {rx_shift_reg[14:0], din_s};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_active_reg <= 1'b0;
      rx_cnt_reg    <= 4'h0;
      rx_shift_reg  <= 16'h0000;
      rx_done_reg   <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (sample_en && rx_active_reg) begin
        rx_shift_reg <= rx_word_next;
        rx_cnt_reg   <= rx_cnt_reg + 4'h1;
        rx_done_reg  <= (rx_cnt_reg == LAST_BIT);
        rx_active_reg <= (rx_cnt_reg != LAST_BIT) | ifs_s;
      end else if (rx_start) begin
        rx_active_reg <= 1'b1;
        rx_cnt_reg    <= 4'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ifs_count_reg <= 4'h0;
      rx_index_reg  <= 4'h0;
    end else if (interval_start) begin
      ifs_count_reg <= 4'h0;
    end else if (rx_start) begin
      ifs_count_reg <= ifs_count_reg + 4'h1;
      rx_index_reg  <= ifs_count_reg + 4'h1;
    end
  end

  // ==========================================================
  // Frame decode
  wire [15:0] rxw      = rx_shift_reg;
  wire [2:0]  rx_addr  = rxw[ADDR_MSB:ADDR_LSB];
  wire [3:0]  rx_reg   = rxw[REG_MSB:REG_LSB];
  wire [7:0]  rx_val   = rxw[VAL_MSB:0];
  wire        own_slot = (rx_index_reg == {1'b0, casc_cnt} + 4'h1);
  // control frames; never in data mode
  wire        is_ctrl  = rx_done_reg &
                         (prog_mode | (mixed_mode & rxw[FLAG_BIT]));
  wire        is_data  = rx_done_reg & own_slot &
                         (data_mode | (mixed_mode & ~rxw[FLAG_BIT]));
  wire        ctrl_own = is_ctrl & (rx_addr == 3'h0);
  wire        ctrl_fwd = is_ctrl & (rx_addr != 3'h0);
  wire        cfg_wr   = ctrl_own & cfg_open;
  wire [15:0] fwd_word = {rxw[15], rx_addr - ADDR_ONE, rxw[11:0]};
  wire [15:0] dac_word = mixed_mode ? {rxw[14:0], 1'b0} : rxw;

  // loop bits only clear in mixed mode
  wire [7:0] mode_wr = {rx_val[7:4],
                        rx_val[MODE_SLP_BIT] | (sloop & ~mixed_mode),
                        rx_val[MODE_DLP_BIT] | (dloop & ~mixed_mode),
                        rx_val[1:0]};

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_config_register <= MODE_RESET;
      rate_config_register <= RATE_RESET;
      loop_config_register <= LOOP_RESET;
      rate_written_reg     <= 1'b0;
    end else if (cfg_wr) begin
      if (rx_reg == REG_MODE) begin
        mode_config_register <= mode_wr;
      end
      if (rx_reg == REG_RATE) begin
        rate_config_register <= rx_val;
        rate_written_reg     <= 1'b1;
      end
      if (rx_reg == REG_LOOP) begin
        loop_config_register <= rx_val;
      end
    end
  end

  // ==========================================================
  // DAC register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dac_data_reg <= 16'h0000;
      dac_load     <= 1'b0;
    end else begin
      dac_load <= 1'b0;
      if (dloop && fs_tick) begin
        dac_data_reg <= adc_sample;
        dac_load     <= 1'b1;
      end else if (!dloop && is_data) begin
        dac_data_reg <= dac_word;
        dac_load     <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Transmitter
  // One idle bit separates words, so the sync always leads by one bit.
  csmi_tx_state_t tx_state_reg;
  logic        sample_pend_reg;
  logic        fwd_valid_reg;
  logic [15:0] fwd_word_reg;
  logic [15:0] echo_word_reg;
  logic [15:0] tx_shift_reg;
  logic [3:0]  tx_cnt_reg;
  wire         tx_idle  = (tx_state_reg == CSMI_TX_IDLE);
  wire         take_smp = launch_en & tx_idle & sample_pend_reg;
  wire         take_fwd = launch_en & tx_idle & ~sample_pend_reg &
                          fwd_valid_reg;
  wire [15:0]  adc_word = mixed_mode ? {1'b0, adc_sample[14:0]}
                                     : adc_sample;
  wire [15:0]  smp_word = sloop ? echo_word_reg : adc_word;

  assign interval_start = take_smp;

  // New events win over the clear of the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sample_pend_reg <= 1'b0;
      fwd_valid_reg   <= 1'b0;
      fwd_word_reg    <= 16'h0000;
      echo_word_reg   <= 16'h0000;
      sample_strobe   <= 1'b0;
    end else begin
      sample_strobe   <= fs_tick;
      sample_pend_reg <= fs_tick | (sample_pend_reg & ~take_smp);
      fwd_valid_reg   <= ctrl_fwd | (fwd_valid_reg & ~take_fwd);
      if (ctrl_fwd) begin
        fwd_word_reg <= fwd_word;
      end
      if (rx_done_reg) begin
        echo_word_reg <= rxw;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_state_reg      <= CSMI_TX_IDLE;
      tx_shift_reg      <= 16'h0000;
      tx_cnt_reg        <= 4'h0;
      output_frame_sync <= 1'b0;
      serial_data_out   <= 1'b0;
    end else if (launch_en) begin
      unique case (tx_state_reg)
        CSMI_TX_IDLE: begin
          serial_data_out <= 1'b0;
          if (take_smp || take_fwd) begin
            output_frame_sync <= 1'b1;
            tx_shift_reg      <= take_smp ? smp_word : fwd_word_reg;
            tx_state_reg      <= CSMI_TX_SYNC;
          end
        end
        CSMI_TX_SYNC: begin
          output_frame_sync <= 1'b0;
          serial_data_out   <= tx_shift_reg[15];
          tx_shift_reg      <= {tx_shift_reg[14:0], 1'b0};
          tx_cnt_reg        <= 4'h0;
          tx_state_reg      <= CSMI_TX_BITS;
        end
        CSMI_TX_BITS: begin
          if (tx_cnt_reg == LAST_BIT) begin
            serial_data_out <= 1'b0;
            tx_state_reg    <= CSMI_TX_IDLE;
          end else begin
            serial_data_out <= tx_shift_reg[15];
            tx_shift_reg    <= {tx_shift_reg[14:0], 1'b0};
            tx_cnt_reg      <= tx_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== tb/csmi_codec_serial_monitor.sv ====
// Port checker for the codec serial front end.
`default_nettype none

module csmi_codec_serial_monitor (
  // Clock, reset and enable
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        serial_enable_pin,
  // Serial timing
  input wire logic        serial_clock_reg,
  input wire logic        output_frame_sync,
  input wire logic        sample_strobe,
  // Converter and configuration
  input wire logic [15:0] dac_data_reg,
  input wire logic        dac_load,
  input wire logic [7:0]  mode_config_register,
  input wire logic [7:0]  rate_config_register,
  input wire logic [7:0]  loop_config_register
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Sample interval measurement
  // An interval in which the rate changed is skipped, since the
  // switch-over point inside it is the design's own choice.
  logic [11:0] gap_reg;
  logic        seen_reg;
  logic        chg_reg;
  // Frame syncs may only follow an enable seen since reset.
  logic        enable_seen_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_reg  <= 12'h000;
      seen_reg <= 1'b0;
      chg_reg  <= 1'b0;
      enable_seen_reg <= 1'b0;
    end else begin
      enable_seen_reg <= enable_seen_reg | serial_enable_pin;
      gap_reg  <= sample_strobe ? 12'h000 : gap_reg + 12'h001;
      seen_reg <= seen_reg | sample_strobe;
      chg_reg  <= $changed(rate_config_register) |
                  (chg_reg & !sample_strobe);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sclk_high_a: assert property ($fell(serial_clock_reg) |->
    (!serial_clock_reg)[*4] ##1 serial_clock_reg[*4] ##1
    !serial_clock_reg)
    else $error("serial clock phases are not four cycles each");
  fsync_width_a: assert property ($rose(output_frame_sync) |->
    output_frame_sync[*8] ##1 !output_frame_sync)
    else $error("output frame sync is not one serial bit wide");
  fsync_align_a: assert property ($rose(output_frame_sync) |->
    $rose(serial_clock_reg))
    else $error("output frame sync not on a serial clock edge");
  fsync_off_a: assert property ($rose(output_frame_sync) |->
    enable_seen_reg)
    else $error("output frame sync before serial port enabled");
  fsync_period_a: assert property (sample_strobe && seen_reg &&
    !chg_reg && !$changed(rate_config_register) |-> gap_reg ==
    12'((12'h100 << ~rate_config_register[1:0]) - 12'h001))
    else $error("sample interval does not match the rate setting");
  dac_hold_a: assert property (!dac_load |->
    $stable(dac_data_reg))
    else $error("converter register changed without a load pulse");
  mode_lock_a: assert property (mode_config_register[1:0] == 2'h1
    |=> $stable(mode_config_register) && $stable(rate_config_register)
    && $stable(loop_config_register))
    else $error("configuration changed in plain data mode");
  mixed_lsb_a: assert property (dac_load &&
    mode_config_register[3:0] == 4'h3 &&
    mode_config_register == $past(mode_config_register, 2)
    |-> !dac_data_reg[0])
    else $error("mixed mode converter word has its low bit set");

  cover property (dac_load && mode_config_register[1:0] == 2'h3);
  cover property (mode_config_register[3]);
  cover property ($rose(output_frame_sync) && rate_config_register[1]);
endmodule

`default_nettype wire

// ==== tb/csmi_host_model.sv ====
// Host serial port model: sends and receives framed 16-bit words.
`default_nettype none

module csmi_host_model (
  // Lines from the codec
  input  wire logic serial_clock_reg,
  input  wire logic output_frame_sync,
  input  wire logic serial_data_out,
  // Lines to the codec
  output var  logic serial_data_in,
  output var  logic input_frame_sync
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Transmit
  initial begin
    serial_data_in   = 1'b0;
    input_frame_sync = 1'b0;
  end

  task automatic send_word(input logic [15:0] w);
    @(posedge serial_clock_reg);
    input_frame_sync <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge serial_clock_reg);
      input_frame_sync <= 1'b0;
      serial_data_in   <= w[i];
    end
    // The line is not held after the word, so it shows the inverse.
    @(posedge serial_clock_reg);
    serial_data_in <= ~w[0];
  endtask

  // ==========================================================
  // Receive
  // sync bit then sixteen bits
  task automatic get_word(output logic [15:0] w);
    w = 16'h0000;
    @(posedge output_frame_sync);
    @(negedge serial_clock_reg);
    repeat (16) begin
      @(negedge serial_clock_reg);
      w = {w[14:0], serial_data_out};
    end
  endtask
endmodule

`default_nettype wire

// ==== tb/codec_serial_mode_interpreter_bench.sv ====
// Self-checking bench for the codec serial front end.
`default_nettype none

module codec_serial_mode_interpreter_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys, rst, serial_enable_pin, serial_data_in;
  logic        input_frame_sync, serial_clock_reg, output_frame_sync;
  logic        serial_data_out, sample_strobe, dac_load;
  logic [15:0] adc_sample, dac_data_reg;
  logic [7:0]  mode_config_register, rate_config_register;
  logic [7:0]  loop_config_register;
  int          errors, comparisons;

  csmi_codec_serial csmi_codec_serial_i (.clk_sys, .rst,
    .serial_enable_pin, .serial_data_in, .input_frame_sync,
    .serial_clock_reg, .output_frame_sync, .serial_data_out,
    .adc_sample, .sample_strobe, .dac_data_reg, .dac_load,
    .mode_config_register, .rate_config_register,
    .loop_config_register);
  csmi_host_model csmi_host_model_i (.serial_clock_reg,
    .output_frame_sync, .serial_data_out, .serial_data_in,
    .input_frame_sync);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic reset_dut();
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  task automatic ctl(input logic [15:0] w);
    csmi_host_model_i.send_word(w);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic wait_load();
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (dac_load !== 1'b1 && n < 3000);
  endtask

  // Data starts right after an output sync, so it is the first slot.
  task automatic data(input logic [15:0] w, input logic [15:0] exp);
    @(posedge output_frame_sync);
    fork
      csmi_host_model_i.send_word(w);
    join_none
    wait_load();
    chk(dac_data_reg, exp);
    repeat (40) @(posedge clk_sys);
  endtask

  task automatic find(input logic [15:0] exp);
    logic [15:0] w;
    w = ~exp;
    for (int i = 0; i < 4 && w !== exp; i++)
      csmi_host_model_i.get_word(w);
    chk(w, exp);
  endtask

  task automatic period(input int exp);
    int n;
    n = 0;
    @(posedge sample_strobe);
    do begin
      @(negedge clk_sys);
      n++;
    end while (!(sample_strobe === 1'b1 && n > 1) && n < 5000);
    chk(16'(n - 1), 16'(exp));
  endtask

  // ==========================================================
  // Watchdog and main sequence
  initial begin
    #9_000_000;
    errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    serial_enable_pin = 1'b0;
    adc_sample = 16'hf0f0;
    errors = 0;
    comparisons = 0;
    reset_dut();
    repeat (10) @(posedge clk_sys);
    serial_enable_pin <= 1'b1;
    period(2048);
    ctl(16'h8102);
    chk({8'h00, rate_config_register}, 16'h0002);
    period(512);
    ctl(16'h2105);
    chk({8'h00, rate_config_register}, 16'h0002);
    find(16'h1105);
    ctl(16'h0003);
    chk({8'h00, mode_config_register}, 16'h0003);
    find(16'h70f0);
    data(16'h2abc, 16'h5578);
    ctl(16'h8580);
    chk({8'h00, loop_config_register}, 16'h0080);
    adc_sample <= 16'h1357;
    ctl(16'h8007);
    wait_load();
    chk(dac_data_reg, 16'h1357);
    ctl(16'h8003);
    chk({8'h00, mode_config_register}, 16'h0003);
    ctl(16'h8001);
    chk({8'h00, mode_config_register}, 16'h0001);
    data(16'hbeef, 16'hbeef);
    data(16'h0103, 16'h0103);
    chk({8'h00, rate_config_register}, 16'h0002);
    reset_dut();
    chk({8'h00, mode_config_register}, 16'h0000);
    ctl(16'h0008);
    ctl(16'h0277);
    find(16'h0277);
    reset_dut();
    ctl(16'h0013);
    @(posedge output_frame_sync);
    fork
      begin
        csmi_host_model_i.send_word(16'h0002);
        csmi_host_model_i.send_word(16'h0004);
      end
    join_none
    wait_load();
    chk(dac_data_reg, 16'h0008);
    report_and_stop();
  end
endmodule

bind csmi_codec_serial csmi_codec_serial_monitor
  csmi_codec_serial_monitor_i (.clk_sys, .rst, .serial_enable_pin,
  .serial_clock_reg, .output_frame_sync, .sample_strobe, .dac_data_reg,
  .dac_load, .mode_config_register, .rate_config_register,
  .loop_config_register);

`default_nettype wire
